// [core/metering_cfg_pkg.sv]
// constants and carrier types for the filter and energy configuration registers
package metering_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] ADDR_FILTER_PERIOD_CONFIG = 12'h4af;
  localparam logic [11:0] ADDR_ENERGY_POWER_CONFIG  = 12'h4b0;
  localparam logic [11:0] ADDR_ENERGY_BASE          = 12'h4c0;
  localparam int          NUM_ENERGY                = 6;
  localparam int          ENERGY_W                  = 32;
  localparam int          PERIOD_W                  = 32;
  localparam int          DATA_W                    = 32;
  localparam int          NUM_PHASE                 = 3;

  // energy register order behind ADDR_ENERGY_BASE
  localparam int IDX_ACTIVE_TOTAL   = 0;
  localparam int IDX_REACTIVE_TOTAL = 1;
  localparam int IDX_APPARENT_TOTAL = 2;
  localparam int IDX_ACTIVE_FUND    = 3;
  localparam int IDX_REACTIVE_FUND  = 4;
  localparam int IDX_APPARENT_FUND  = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int USER_PERIOD_SEL_BIT = 12;
  localparam int HPF_CORNER_LSB      = 9;
  localparam int NOLOAD_LSB          = 13;
  localparam int SIGN_REACTIVE_BIT   = 7;
  localparam int SIGN_ACTIVE_BIT     = 6;
  localparam int CLEAR_ON_READ_BIT   = 5;
  localparam int OVERWRITE_BIT       = 4;

  // reset values and codes
  localparam logic [2:0]  HPF_CORNER_RST      = 3'h6;
  localparam logic [2:0]  NOLOAD_RST          = 3'h0;
  localparam logic [2:0]  NOLOAD_OFF_CODE     = 3'h7;
  localparam logic [12:0] NOLOAD_BASE_SAMPLES = 13'h0040;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [11:0]       addr;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic [NUM_PHASE-1:0] total_active;
    logic [NUM_PHASE-1:0] fund_active;
    logic [NUM_PHASE-1:0] total_reactive;
    logic [NUM_PHASE-1:0] fund_reactive;
  } phase_sign_s;

endpackage

// [core/metering_filter_energy_config.sv]
// filter, period and energy configuration registers with energy user registers
// How it works
// - user-period bit picks user or phase period
// - three-bit corner code, reset 6, when enabled
// - no-load window 64..4096 samples, code 7 off
// - bit 7 picks reactive reverse-flag sign source
// - bit 6 picks active reverse-flag sign source
// - clear-on-read zeroes each read energy register
// - overwrite bit clear adds internal energy in
// - overwrite bit set replaces on energy-ready event
`timescale 1ns/1ps
module metering_filter_energy_config (
  // clock and reset
  input  wire logic                                         ref_clk_i,
  input  wire logic                                         nrst_i,
  // host register port
  input  wire metering_cfg_pkg::host_req_s                  host_req_i,
  output logic [metering_cfg_pkg::DATA_W-1:0]               reg_rdata_o,
  // line period sources
  input  wire logic [metering_cfg_pkg::PERIOD_W-1:0]        user_period_i,
  input  wire logic [metering_cfg_pkg::NUM_PHASE-1:0][metering_cfg_pkg::PERIOD_W-1:0]
                                                            phase_period_i,
  input  wire logic [1:0]                                   line_period_source_i,
  output logic [metering_cfg_pkg::PERIOD_W-1:0]             line_period_o,
  // high-pass filter
  input  wire logic                                         highpass_disable_i,
  output logic [2:0]                                        highpass_corner_code_o,
  output logic                                              highpass_en_o,
  // no-load window
  output logic [12:0]                                       noload_samples_o,
  output logic                                              noload_off_o,
  // reverse-power flags
  input  wire metering_cfg_pkg::phase_sign_s                power_sign_i,
  output logic [metering_cfg_pkg::NUM_PHASE-1:0]            active_reverse_flag_o,
  output logic [metering_cfg_pkg::NUM_PHASE-1:0]            reactive_reverse_flag_o,
  // energy accumulation
  input  wire logic                                         energy_ready_event_i,
  input  wire logic [metering_cfg_pkg::NUM_ENERGY-1:0][metering_cfg_pkg::ENERGY_W-1:0]
                                                            energy_internal_i
);
  import metering_cfg_pkg::*;

  typedef struct packed {
    logic                                 user_period_select;
    logic [2:0]                           highpass_corner_code;
    logic [2:0]                           noload_window_code;
    logic [1:0]                           power_sign_source;
    logic                                 clear_on_read;
    logic                                 energy_overwrite_mode;
    logic [NUM_ENERGY-1:0][ENERGY_W-1:0]  energy;
    logic [DATA_W-1:0]                    rdata;
    logic [PERIOD_W-1:0]                  line_period;
    logic                                 hpf_en;
    logic [12:0]                          noload_samples;
    logic                                 noload_off;
    logic [NUM_PHASE-1:0]                 act_rev;
    logic [NUM_PHASE-1:0]                 react_rev;
  } state_s;

  state_s                               state;
  state_s                               next_state;
  logic [NUM_ENERGY-1:0]                rd_hit;
  logic [NUM_ENERGY-1:0][ENERGY_W-1:0]  energy_next;
  logic [PERIOD_W-1:0]                  phase_period_sel;
  logic [2:0]                           energy_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // per-register energy update
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENERGY; gi++) begin : g_energy
      logic [ENERGY_W-1:0] base;
      assign rd_hit[gi] = host_req_i.rd && (host_req_i.addr == ADDR_ENERGY_BASE + 12'(gi));
      // read resets register
      // the read still returns the old value; accumulation restarts from zero
      assign base = (rd_hit[gi] && state.clear_on_read) ? '0 : state.energy[gi];
      // overwrite when set
      // a same-cycle ready event is never lost against a clearing read
      assign energy_next[gi] = !energy_ready_event_i     ? base :
                               state.energy_overwrite_mode ? energy_internal_i[gi] :
                               base + energy_internal_i[gi];
    end
  endgenerate

  // line period source code 3 has no phase behind it and falls back to phase a
  always_comb begin
    case (line_period_source_i)
      2'h1:    phase_period_sel = phase_period_i[1];
      2'h2:    phase_period_sel = phase_period_i[2];
      default: phase_period_sel = phase_period_i[0];
    endcase
  end

  assign energy_idx = 3'(host_req_i.addr - ADDR_ENERGY_BASE);

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state        = state;
    next_state.energy = energy_next;
    if (host_req_i.wr) begin
      case (host_req_i.addr)
        ADDR_FILTER_PERIOD_CONFIG: begin
          next_state.user_period_select   = host_req_i.wdata[USER_PERIOD_SEL_BIT];
          next_state.highpass_corner_code = host_req_i.wdata[HPF_CORNER_LSB +: 3];
        end
        ADDR_ENERGY_POWER_CONFIG: begin
          next_state.noload_window_code    = host_req_i.wdata[NOLOAD_LSB +: 3];
          next_state.power_sign_source     = host_req_i.wdata[SIGN_REACTIVE_BIT -: 2];
          next_state.clear_on_read         = host_req_i.wdata[CLEAR_ON_READ_BIT];
          next_state.energy_overwrite_mode = host_req_i.wdata[OVERWRITE_BIT];
        end
        default: ;
      endcase
    end
    if (host_req_i.rd) begin
      next_state.rdata = '0;
      case (host_req_i.addr)
        ADDR_FILTER_PERIOD_CONFIG: begin
          next_state.rdata[USER_PERIOD_SEL_BIT]   = state.user_period_select;
          next_state.rdata[HPF_CORNER_LSB +: 3]   = state.highpass_corner_code;
        end
        ADDR_ENERGY_POWER_CONFIG: begin
          next_state.rdata[NOLOAD_LSB +: 3]        = state.noload_window_code;
          next_state.rdata[SIGN_REACTIVE_BIT -: 2] = state.power_sign_source;
          next_state.rdata[CLEAR_ON_READ_BIT]      = state.clear_on_read;
          next_state.rdata[OVERWRITE_BIT]          = state.energy_overwrite_mode;
        end
        default: begin
          if (|rd_hit) begin
            next_state.rdata = state.energy[energy_idx];
          end
        end
      endcase
    end
    next_state.line_period = state.user_period_select ? user_period_i : phase_period_sel;
    next_state.hpf_en = !highpass_disable_i;
    if (state.noload_window_code == NOLOAD_OFF_CODE) begin
      next_state.noload_samples = '0;
      next_state.noload_off     = 1'b1;
    end else begin
      next_state.noload_samples = NOLOAD_BASE_SAMPLES << state.noload_window_code;
      next_state.noload_off     = 1'b0;
    end
    next_state.act_rev   = state.power_sign_source[0] ? power_sign_i.fund_active :
                                                        power_sign_i.total_active;
    next_state.react_rev = state.power_sign_source[1] ? power_sign_i.fund_reactive :
                                                        power_sign_i.total_reactive;
    if (!nrst_i) begin
      next_state                      = '0;
      next_state.highpass_corner_code = HPF_CORNER_RST;
      next_state.noload_window_code   = NOLOAD_RST;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata_o             = state.rdata;
  assign line_period_o           = state.line_period;
  assign highpass_corner_code_o  = state.highpass_corner_code;
  assign highpass_en_o           = state.hpf_en;
  assign noload_samples_o        = state.noload_samples;
  assign noload_off_o            = state.noload_off;
  assign active_reverse_flag_o   = state.act_rev;
  assign reactive_reverse_flag_o = state.react_rev;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_user_period;
    state.user_period_select |=> line_period_o == $past(user_period_i);
  endproperty
  a_user_period: assert property (p_user_period) else $error("user period not used");

  property p_phase_period;
    !state.user_period_select && line_period_source_i == 2'h2
      |=> line_period_o == $past(phase_period_i[2]);
  endproperty
  a_phase_period: assert property (p_phase_period) else $error("phase period wrong");

  property p_corner_reset;
    $rose(nrst_i) |-> highpass_corner_code_o == HPF_CORNER_RST && noload_samples_o == '0;
  endproperty
  a_corner_reset: assert property (p_corner_reset) else $error("bad reset values");

  property p_corner_write;
    host_req_i.wr && host_req_i.addr == ADDR_FILTER_PERIOD_CONFIG
      |=> highpass_corner_code_o == $past(host_req_i.wdata[11:9]);
  endproperty
  a_corner_write: assert property (p_corner_write) else $error("corner not stored");

  property p_noload_len;
    host_req_i.wr && host_req_i.addr == ADDR_ENERGY_POWER_CONFIG &&
      host_req_i.wdata[15:13] == 3'h6
      ##1 !host_req_i.wr |=> noload_samples_o == 13'h1000 && !noload_off_o;
  endproperty
  a_noload_len: assert property (p_noload_len) else $error("window length wrong");

  property p_noload_off;
    state.noload_window_code == 3'h7 |=> noload_off_o && noload_samples_o == '0;
  endproperty
  a_noload_off: assert property (p_noload_off) else $error("no-load not off");

  property p_react_sign;
    !state.power_sign_source[1] |=> reactive_reverse_flag_o == $past(power_sign_i.total_reactive);
  endproperty
  a_react_sign: assert property (p_react_sign) else $error("reactive sign source");

  property p_act_sign;
    state.power_sign_source[0] |=> active_reverse_flag_o == $past(power_sign_i.fund_active);
  endproperty
  a_act_sign: assert property (p_act_sign) else $error("active sign source");

  property p_clear_read;
    rd_hit[0] && state.clear_on_read && !energy_ready_event_i
      |=> state.energy[0] == '0 && reg_rdata_o == $past(state.energy[0]);
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("energy not cleared");

  property p_energy_add;
    energy_ready_event_i && !state.energy_overwrite_mode && !rd_hit[0]
      |=> state.energy[0] == $past(state.energy[0]) + $past(energy_internal_i[0]);
  endproperty
  a_energy_add: assert property (p_energy_add) else $error("energy not added");

  property p_energy_over;
    energy_ready_event_i && state.energy_overwrite_mode
      |=> state.energy[1] == $past(energy_internal_i[1]);
  endproperty
  a_energy_over: assert property (p_energy_over) else $error("energy not overwritten");

  property p_reserved;
    host_req_i.rd && host_req_i.addr == ADDR_ENERGY_POWER_CONFIG |=> reg_rdata_o[12:8] == '0 &&
      reg_rdata_o[3:0] == '0 && reg_rdata_o[31:16] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  c_overwrite: cover property (energy_ready_event_i && state.energy_overwrite_mode);
  c_clear:     cover property (|rd_hit && state.clear_on_read);
  c_noload:    cover property (noload_off_o);
  c_user:      cover property (state.user_period_select ##1 host_req_i.rd);

endmodule

// [sim/host_model.sv]
// host model driving the register port with one-cycle strobes
`timescale 1ns/1ps
module host_model (
  // clock and read data
  input  wire logic                          ref_clk_i,
  input  wire logic [31:0]                   rdata_i,
  // request
  output metering_cfg_pkg::host_req_s        req_o
);
  import metering_cfg_pkg::*;
  initial req_o = '0;
  // released address and data lines show inverted values and rd/wr drop to 0, so a stale field cannot pass for a live one
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
    @(posedge ref_clk_i);
    req_o <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(posedge ref_clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    // read data was launched on the previous edge and has settled by this one
    @(posedge ref_clk_i);
    rdata = rdata_i;
  endtask
endmodule

// [sim/metering_filter_energy_config_test.sv]
// self-checking bench for the filter, period and energy configuration registers
`timescale 1ns/1ps
module metering_filter_energy_config_test;
  import metering_cfg_pkg::*;
  typedef struct packed {
    logic [15:0] cfg2;
    logic [15:0] ep;
    logic [12:0] samples;
  } row_s;
  localparam row_s ROWS [8] = '{
    '{16'he1ff, 16'h1f0f, 13'h0040}, '{16'h1200, 16'h20c0, 13'h0080},
    '{16'h0400, 16'h4080, 13'h0100}, '{16'h1600, 16'h6040, 13'h0200},
    '{16'h0800, 16'h8030, 13'h0400}, '{16'h1a00, 16'ha020, 13'h0800},
    '{16'h0c00, 16'hc010, 13'h1000}, '{16'h1e00, 16'he0ff, 13'h0000}};
  logic ref_clk_i, nrst_i, hp_dis, ev;
  logic [1:0] src;
  host_req_s req;
  logic [31:0] rdata, line_period, d, uper;
  logic [2:0] corner, act_flag, react_flag;
  logic hp_en, nl_off;
  logic [12:0] nl_samples;
  logic [NUM_PHASE-1:0][31:0] phase_p;
  logic [NUM_ENERGY-1:0][31:0] internal;
  phase_sign_s signs;
  int n_fail, samples_checked, cycles;

  metering_filter_energy_config metering_filter_energy_config_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .host_req_i(req), .reg_rdata_o(rdata),
    .user_period_i(uper), .phase_period_i(phase_p), .line_period_source_i(src),
    .line_period_o(line_period), .highpass_disable_i(hp_dis),
    .highpass_corner_code_o(corner), .highpass_en_o(hp_en), .noload_samples_o(nl_samples),
    .noload_off_o(nl_off), .power_sign_i(signs), .active_reverse_flag_o(act_flag),
    .reactive_reverse_flag_o(react_flag), .energy_ready_event_i(ev),
    .energy_internal_i(internal));
  host_model host_model_inst (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    host_model_inst.access(1'b1, a, {16'h0000, v}, d);
  endtask

  task automatic rd(input logic [11:0] a);
    host_model_inst.access(1'b0, a, 32'h0, d);
  endtask

  task automatic pulse;
    @(posedge ref_clk_i);
    ev <= 1'b1;
    @(posedge ref_clk_i);
    ev <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // limit set far above the fewer than two hundred cycles the tests need
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    n_fail = 0; samples_checked = 0; cycles = 0;
    nrst_i = 1'b0; hp_dis = 1'b0; ev = 1'b0; src = 2'h0;
    uper = 32'h1111_0000;
    phase_p = {32'h0000_0ccc, 32'h0000_0bbb, 32'h0000_0aaa};
    internal = '0;
    signs = '{total_active: 3'h1, fund_active: 3'h6, total_reactive: 3'h3,
              fund_reactive: 3'h4};
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(ADDR_FILTER_PERIOD_CONFIG);
    chk("cfg2 reset", 32'h0000_0c00, d);
    chk("corner reset", 32'h6, 32'(corner));
    foreach (ROWS[i]) begin
      hp_dis <= i[0];
      // phase rows walk every source code, 3 included
      src <= 2'(i / 2);
      uper <= 32'h1111_0000 + 32'(i);
      wr(ADDR_FILTER_PERIOD_CONFIG, ROWS[i].cfg2);
      wr(ADDR_ENERGY_POWER_CONFIG, ROWS[i].ep);
      rd(ADDR_FILTER_PERIOD_CONFIG);
      chk("cfg2", {16'h0, ROWS[i].cfg2 & 16'h1e00}, d);
      rd(ADDR_ENERGY_POWER_CONFIG);
      chk("ep", {16'h0, ROWS[i].ep & 16'he0f0}, d);
      chk("corner", 32'(ROWS[i].cfg2[11:9]), 32'(corner));
      chk("hp_en", 32'(!i[0]), 32'(hp_en));
      chk("samples", 32'(ROWS[i].samples), 32'(nl_samples));
      chk("off", 32'(ROWS[i].ep[15:13] == 3'h7), 32'(nl_off));
      chk("period", ROWS[i].cfg2[12] ? 32'h1111_0000 + 32'(i) :
          phase_p[(i / 2 == 3) ? 0 : i / 2], line_period);
      chk("act", 32'(ROWS[i].ep[6] ? signs.fund_active : signs.total_active),
          32'(act_flag));
      chk("react", 32'(ROWS[i].ep[7] ? signs.fund_reactive : signs.total_reactive),
          32'(react_flag));
    end
    $display("test rows done");
    // two events in add mode accumulate
    wr(ADDR_ENERGY_POWER_CONFIG, 16'h0000);
    internal <= {NUM_ENERGY{32'h5}};
    pulse();
    pulse();
    rd(ADDR_ENERGY_BASE);
    chk("energy add", 32'ha, d);
    rd(ADDR_ENERGY_BASE + 12'h5);
    chk("energy add last", 32'ha, d);
    wr(ADDR_ENERGY_POWER_CONFIG, 16'h0010);
    internal <= {NUM_ENERGY{32'h7}};
    pulse();
    rd(ADDR_ENERGY_BASE);
    chk("energy load", 32'h7, d);
    wr(ADDR_ENERGY_POWER_CONFIG, 16'h0030);
    rd(ADDR_ENERGY_BASE);
    chk("clear read a", 32'h7, d);
    rd(ADDR_ENERGY_BASE + 12'h3);
    chk("clear read", 32'h7, d);
    rd(ADDR_ENERGY_BASE + 12'h3);
    chk("after clear", 32'h0, d);
    wr(ADDR_ENERGY_BASE + 12'h3, 16'h1234);
    rd(ADDR_ENERGY_BASE + 12'h3);
    chk("energy write", 32'h0, d);
    rd(12'h4c6);
    chk("unmapped", 32'h0, d);
    // clearing read and ready event on one edge: event kept, read sees old value
    wr(ADDR_ENERGY_POWER_CONFIG, 16'h0020);
    internal <= {NUM_ENERGY{32'h9}};
    fork
      pulse();
      rd(ADDR_ENERGY_BASE + 12'h2);
    join
    chk("clear and event old", 32'h7, d);
    rd(ADDR_ENERGY_BASE + 12'h2);
    chk("clear and event new", 32'h9, d);
    $display("test energy done");
    // second reset in mid-run
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(ADDR_ENERGY_POWER_CONFIG);
    chk("ep reset", 32'h0, d);
    rd(ADDR_FILTER_PERIOD_CONFIG);
    chk("cfg2 reset again", 32'h0000_0c00, d);
    rd(ADDR_ENERGY_BASE + 12'h1);
    chk("energy reset", 32'h0, d);
    $display("test reset done");
    report_and_stop();
  end
endmodule
